// *** rtl/switch_device.sv ***
// Device end: command shift path, output latch and fault status for eight channels
`include "switch_map.svh"
// Contract
// [RULE1] Command bit zero turns channel off, one on
// [RULE2] Faulted channel status one, healthy zero
// [RULE3] Chain passes incoming bits on while selected
// [RULE4] One status bit shifted per serial clock
// [RULE5] Command acts only on select rising edge
// [RULE6] Sixteen bit command and status words
// [RULE7] Both words travel most significant bit first
// [RULE8] Bits 0-7 drive channels one to eight
// [RULE9] Bits 8-15 enable open load currents
// [RULE10] Status upper byte always zero
// [RULE11] Status bits 0-7 report channel faults
// [RULE12] Status shows state before new command
// [RULE13] No open load on commanded-on channel
// [RULE14] Off open load needs detection current
// [RULE15] Overtemperature reports a one
// [RULE16] Short or overcurrent reports a one
// [RULE17] Power-on reset when battery supply applied
// [RULE18] Parallel devices each get own select
// [RULE19] Sample on falling, change on rising edge
// [RULE20] Deselected: ignore clock, data; output off
// [RULE21] Accept 16 plus multiples of 8 pulses
// [RULE22] Direct drives five, six ORed with bits
// [RULE23] Reset clears command and shift registers
// [RULE24] Faults synchronised, captured at select fall
module switch_device (
	// System
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Direct drive pins for channels five and six
	input  wire logic             direct_drive_five_i,
	input  wire logic             direct_drive_six_i,
	// Fault sense per channel
	input  wire switch_pkg::chan_t short_fault_i,
	input  wire switch_pkg::chan_t thermal_limit_i,
	input  wire switch_pkg::chan_t open_load_i,
	// Channel controls
	output switch_pkg::chan_t     drive_on_o,
	output switch_pkg::chan_t     detect_en_o,
	output logic                  frame_accepted_o,
	output logic                  frame_rejected_o,
	// Link
	switch_link_if.device         link
);
	import switch_pkg::*;

	// Link domain state
	word_t      shift_sr;
	pulse_cnt_t pulse_cnt;
	logic       out_bit;
	logic       out_en;
	// System domain state
	word_t      cmd;
	word_t      status_snap;
	logic       sel_meta;
	logic       sel_sync;
	logic       sel_prev;
	logic       consumed;
	logic [1:0] dd_meta;
	logic [1:0] dd_sync;
	chan_t      short_meta;
	chan_t      short_sync;
	chan_t      therm_meta;
	chan_t      therm_sync;
	chan_t      open_meta;
	chan_t      open_sync;
	wire chan_t fault_vec;

	wire        cnt_clr;
	wire        out_clr;
	wire        first_bit;
	wire        sel_rise;
	wire        count_ok;
	wire        shift_src;
	chan_t      next_drive;

	// Counter is cleared only after the system side has judged the frame
	assign cnt_clr   = !rst_n_i || (link.select_n && consumed);
	assign out_clr   = !rst_n_i || link.select_n; // [RULE20]
	assign first_bit = (pulse_cnt == '0);
	assign count_ok  = (pulse_cnt == `SW_MIN_PULSES); // [RULE21]
	assign sel_rise  = sel_sync && !sel_prev;
	// First bit out comes from the snapshot; later ones pass the chain through
	assign shift_src = first_bit ? status_snap[`SW_WORD_BITS-1] : shift_sr[`SW_WORD_BITS-1];
	assign link.status_out = out_bit;
	assign link.status_oe  = out_en;

	// Pulse counter; wraps 23 back to 16 so any 16 + 8k count lands on 16
	always_ff @(negedge link.serial_clk or posedge cnt_clr) begin
		if (cnt_clr)
			pulse_cnt <= '0;
		else if (!link.select_n) begin
			if (pulse_cnt == `SW_LAST_PULSE)
				pulse_cnt <= `SW_MIN_PULSES; // [RULE21]
			else
				pulse_cnt <= pulse_cnt + 1'b1;
		end
	end

	// Input shift register samples serial input on the falling edge
	always_ff @(negedge link.serial_clk or negedge rst_n_i) begin
		if (!rst_n_i)
			shift_sr <= `SW_CMD_RESET; // [RULE23]
		else if (!link.select_n) begin
			if (first_bit)
				shift_sr <= {status_snap[`SW_WORD_BITS-2:0], link.serial_in}; // [RULE4]
			else
				shift_sr <= {shift_sr[`SW_WORD_BITS-2:0], link.serial_in}; // [RULE3]
		end
	end

	// Status output changes on the rising edge, MSB first
	// Output enable turns on with the first rising edge, when the first bit is valid
	always_ff @(posedge link.serial_clk or posedge out_clr) begin
		if (out_clr) begin
			out_bit <= 1'b0;
			out_en  <= 1'b0;
		end else begin
			out_bit <= shift_src; // [RULE19]
			out_en  <= 1'b1;
		end
	end

	// Pins from outside the system clock pass two flip-flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_meta   <= 1'b1;
			sel_sync   <= 1'b1;
			sel_prev   <= 1'b1;
			dd_meta    <= '0;
			dd_sync    <= '0;
			short_meta <= '0;
			short_sync <= '0;
			therm_meta <= '0;
			therm_sync <= '0;
			open_meta  <= '0;
			open_sync  <= '0;
		end else begin
			sel_meta   <= link.select_n;
			sel_sync   <= sel_meta;
			sel_prev   <= sel_sync;
			dd_meta    <= {direct_drive_six_i, direct_drive_five_i};
			dd_sync    <= dd_meta;
			short_meta <= short_fault_i;
			short_sync <= short_meta;
			therm_meta <= thermal_limit_i;
			therm_sync <= therm_meta;
			open_meta  <= open_load_i;
			open_sync  <= open_meta; // [RULE24]
		end
	end

	// Per-channel fault qualification against the present drive state
	genvar ch;
	generate
		for (ch = 0; ch < `SW_CHANNELS; ch++) begin : g_chan
			assign fault_vec[ch] = short_sync[ch]                     // [RULE16]
				|| therm_sync[ch]                                     // [RULE15]
				|| (open_sync[ch] && !drive_on_o[ch] && detect_en_o[ch]); // [RULE13] [RULE14]
		end
	endgenerate

	// Direct drives only add to the command bits of channels five and six
	always_comb begin
		next_drive = cmd[`SW_OUT_LSB +: `SW_CHANNELS]; // [RULE1] [RULE8]
		next_drive[`SW_CH5_BIT] = cmd[`SW_OUT_LSB + `SW_CH5_BIT] || dd_sync[0]; // [RULE22]
		next_drive[`SW_CH6_BIT] = cmd[`SW_OUT_LSB + `SW_CH6_BIT] || dd_sync[1]; // [RULE22]
	end

	// Snapshot tracks faults while deselected and freezes once select falls.
	// The link side reads it only in a frame, when it is already frozen.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			status_snap <= '0;
		else if (sel_sync)
			status_snap <= {`SW_STATUS_HIGH, fault_vec}; // [RULE2] [RULE10] [RULE11] [RULE12] [RULE24]
	end

	// Command takes effect on the select rising edge only.
	// The shift register and counter are quiet then, so reading them here is safe.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmd              <= `SW_CMD_RESET; // [RULE17] [RULE23]
			consumed         <= 1'b0;
			frame_accepted_o <= 1'b0;
			frame_rejected_o <= 1'b0;
		end else begin
			frame_accepted_o <= 1'b0;
			frame_rejected_o <= 1'b0;
			if (!sel_sync)
				consumed <= 1'b0;
			else if (sel_rise) begin
				consumed <= 1'b1;
				if (count_ok) begin
					cmd              <= shift_sr; // [RULE5] [RULE6]
					frame_accepted_o <= 1'b1;
				end else
					frame_rejected_o <= 1'b1; // [RULE21]
			end
		end
	end

	// Drive and detection controls
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_on_o  <= '0;
			detect_en_o <= '0;
		end else begin
			drive_on_o  <= next_drive;
			detect_en_o <= cmd[`SW_DET_LSB +: `SW_CHANNELS]; // [RULE9]
		end
	end
endmodule // switch_device

// *** rtl/switch_host.sv ***
// Bus master end: makes the serial clock and runs one frame per request
`include "switch_map.svh"
module switch_host #(
	parameter int FRAME_BITS = `SW_WORD_BITS
) (
	// System
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	// Request and answer
	input  wire logic                  start_i,
	input  wire logic [FRAME_BITS-1:0] tx_word_i,
	output logic                       busy_o,
	output logic                       done_o,
	output logic [FRAME_BITS-1:0]      rx_word_o,
	// Link
	switch_link_if.host                link
);
	import switch_pkg::*;

	localparam logic [`SW_TIMER_WIDTH-1:0] HALF = `SW_TIMER_WIDTH'(`SW_HALF_CYC - 1);
	localparam logic [`SW_TIMER_WIDTH-1:0] LEAD = `SW_TIMER_WIDTH'(`SW_LEAD_CYC - 1);
	localparam logic [`SW_TIMER_WIDTH-1:0] LAG  = `SW_TIMER_WIDTH'(`SW_LAG_CYC - 1);
	localparam logic [`SW_TIMER_WIDTH-1:0] GAP  = `SW_TIMER_WIDTH'(`SW_GAP_CYC - 1);
	localparam logic [7:0]                 LAST = 8'(FRAME_BITS - 1);

	host_state_t                 state;
	logic [`SW_TIMER_WIDTH-1:0]  timer;
	logic [7:0]                  bit_idx;
	logic [FRAME_BITS-1:0]       tx_sr;
	logic [FRAME_BITS-1:0]       rx_sr;
	logic                        line_meta;
	logic                        line_sync;
	logic                        sclk;
	logic                        sel_n;
	logic                        mosi;
	wire                         timer_done;

	assign timer_done = (timer == '0);
	assign link.serial_clk = sclk;
	assign link.select_n   = sel_n;
	assign link.serial_in  = mosi;

	// Returned status comes from another party, so it is synchronised first
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			line_meta <= 1'b0;
			line_sync <= 1'b0;
		end else begin
			line_meta <= link.status_line;
			line_sync <= line_meta;
		end
	end

	// Frame sequencer; the clock idles low so select edges never meet a high clock
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state     <= HOST_IDLE;
			timer     <= '0;
			bit_idx   <= '0;
			tx_sr     <= '0;
			rx_sr     <= '0;
			sclk      <= 1'b0;
			sel_n     <= 1'b1;
			mosi      <= 1'b0;
			busy_o    <= 1'b0;
			done_o    <= 1'b0;
			rx_word_o <= '0;
		end else begin
			done_o <= 1'b0;
			if (!timer_done)
				timer <= timer - 1'b1;
			case (state)
				HOST_IDLE: begin
					if (start_i) begin
						tx_sr   <= tx_word_i << 1;
						mosi    <= tx_word_i[FRAME_BITS-1]; // [RULE7]
						sel_n   <= 1'b0; // [RULE3]
						busy_o  <= 1'b1;
						bit_idx <= '0;
						timer   <= LEAD;
						state   <= HOST_LEAD;
					end
				end
				HOST_LEAD: begin
					if (timer_done) begin
						sclk  <= 1'b1;
						timer <= HALF;
						state <= HOST_HIGH;
					end
				end
				HOST_HIGH: begin
					if (timer_done) begin
						// Sample just before the falling edge; device changed on the rising one
						rx_sr <= {rx_sr[FRAME_BITS-2:0], line_sync}; // [RULE19]
						sclk  <= 1'b0;
						timer <= HALF;
						state <= HOST_LOW;
					end
				end
				HOST_LOW: begin
					if (timer_done) begin
						if (bit_idx == LAST) begin
							timer <= LAG;
							state <= HOST_LAG;
						end else begin
							mosi    <= tx_sr[FRAME_BITS-1]; // [RULE6]
							tx_sr   <= tx_sr << 1;
							bit_idx <= bit_idx + 1'b1;
							sclk    <= 1'b1;
							timer   <= HALF;
							state   <= HOST_HIGH;
						end
					end
				end
				HOST_LAG: begin
					if (timer_done) begin
						sel_n     <= 1'b1;
						mosi      <= 1'b0;
						rx_word_o <= rx_sr;
						done_o    <= 1'b1;
						timer     <= GAP;
						state     <= HOST_GAP;
					end
				end
				HOST_GAP: begin
					// Lets the device act on the select rising edge before the next frame
					if (timer_done) begin
						busy_o <= 1'b0;
						state  <= HOST_IDLE;
					end
				end
				default: state <= HOST_IDLE;
			endcase
		end
	end
endmodule // switch_host

// *** rtl/switch_link_if.sv ***
// Serial link between the bus master and the octal switch control logic
interface switch_link_if;
	logic serial_clk;
	logic select_n;
	logic serial_in;
	logic status_out;
	logic status_oe;
	wire  status_line;

	// A released line shows the inverse of status_out, which the device clears together with the enable, so the host reads a one
	assign status_line = status_oe ? status_out : ~status_out;

	modport device (
		input  serial_clk,
		input  select_n,
		input  serial_in,
		output status_out,
		output status_oe
	);

	modport host (
		output serial_clk,
		output select_n,
		output serial_in,
		input  status_line
	);
endinterface

// *** rtl/switch_map.svh ***
// Constant map for the serial octal switch control link and its two ends
`ifndef SWITCH_MAP_SVH
`define SWITCH_MAP_SVH

// Word layout
`define SW_WORD_BITS     16
`define SW_CHANNELS      8
`define SW_OUT_LSB       0
`define SW_DET_LSB       8
`define SW_CH5_BIT       4
`define SW_CH6_BIT       5
`define SW_CMD_RESET     16'h0000
`define SW_STATUS_HIGH   8'h00

// Pulse count acceptance: 16 pulses, then whole steps of 8
`define SW_CNT_WIDTH     5
`define SW_MIN_PULSES    5'h10
`define SW_LAST_PULSE    5'h17

// Timing, in ns, and derived cycle counts at the system clock
`define SW_CLK_NS        25
`define SW_SCLK_HALF_NS  125
`define SW_LEAD_NS       100
`define SW_LAG_NS        50
`define SW_GAP_NS        250
`define SW_HALF_CYC      ((`SW_SCLK_HALF_NS + `SW_CLK_NS - 1) / `SW_CLK_NS)
`define SW_LEAD_CYC      ((`SW_LEAD_NS + `SW_CLK_NS - 1) / `SW_CLK_NS)
`define SW_LAG_CYC       ((`SW_LAG_NS + `SW_CLK_NS - 1) / `SW_CLK_NS)
`define SW_GAP_CYC       ((`SW_GAP_NS + `SW_CLK_NS - 1) / `SW_CLK_NS)
`define SW_TIMER_WIDTH   8

`endif

// *** rtl/switch_pkg.sv ***
// Types shared by both ends of the serial switch control link
`include "switch_map.svh"
package switch_pkg;
	typedef logic [`SW_WORD_BITS-1:0] word_t;
	typedef logic [`SW_CHANNELS-1:0]  chan_t;
	typedef logic [`SW_CNT_WIDTH-1:0] pulse_cnt_t;

	// Master sequence, Gray coded along idle-lead-high-low-lag-gap
	typedef enum logic [2:0] {
		HOST_IDLE = 3'h0,
		HOST_LEAD = 3'h1,
		HOST_HIGH = 3'h3,
		HOST_LOW  = 3'h2,
		HOST_LAG  = 3'h6,
		HOST_GAP  = 3'h7
	} host_state_t;
endpackage

// *** verif/spi_octal_switch_control_test.sv ***
// Testbench joining both link ends, with a second pair that sends a bad pulse count
module spi_octal_switch_control_test import switch_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [15:0] cmd; chan_t sh; chan_t th; chan_t ol; logic d5; logic d6;
		chan_t st; chan_t dr;} row_t;
	logic        clk_i, rst_n_i, start_i, start2, busy_o, done_o, d5, d6, acc, rej, rej2, seen_rej;
	logic [31:0] tx_word, rx_word;
	logic [15:0] cmd;
	chan_t       sh, th, ol, drive_on_o, detect_en_o, drive2, det2, exp_dr, exp_st;
	int          fails, checked, cycles, n_acc, n_done;
	// Row: command, short, thermal, open load, direct drives, then status and drive expected.
	// Status is judged against the previous row's command, open load counting only where it left detection on.
	row_t rows [7] = '{
		'{16'h0000, 8'h00, 8'h00, 8'h00, 1'h0, 1'h0, 8'h00, 8'h00},
		'{16'hFF0F, 8'h00, 8'h00, 8'hFF, 1'h0, 1'h0, 8'h00, 8'h0F},
		'{16'h00F0, 8'h00, 8'h00, 8'hFF, 1'h0, 1'h0, 8'hF0, 8'hF0},
		'{16'h0000, 8'h01, 8'h80, 8'hFF, 1'h0, 1'h0, 8'h81, 8'h00},
		'{16'h0000, 8'h00, 8'h00, 8'h00, 1'h1, 1'h0, 8'h00, 8'h10},
		'{16'hFF00, 8'h00, 8'h00, 8'hFF, 1'h0, 1'h1, 8'h00, 8'h20},
		'{16'h0000, 8'h00, 8'h00, 8'hFF, 1'h0, 1'h0, 8'hFF, 8'h00}};
	switch_link_if link1 ();
	// Each pair has a select line of its own
	switch_link_if link2 ();
	switch_host #(.FRAME_BITS(32)) u_switch_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
		.tx_word_i(tx_word), .busy_o(busy_o), .done_o(done_o), .rx_word_o(rx_word), .link(link1.host));
	switch_device u_switch_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .direct_drive_five_i(d5),
		.direct_drive_six_i(d6), .short_fault_i(sh), .thermal_limit_i(th), .open_load_i(ol), .drive_on_o(drive_on_o),
		.detect_en_o(detect_en_o), .frame_accepted_o(acc), .frame_rejected_o(rej), .link(link1.device));
	switch_link_props u_switch_link_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .serial_clk(link1.serial_clk),
		.select_n(link1.select_n), .status_out(link1.status_out), .status_oe(link1.status_oe),
		.drive_on_o(drive_on_o), .detect_en_o(detect_en_o), .frame_accepted_o(acc), .frame_rejected_o(rej));
	// Twenty pulses is not 16 plus a multiple of 8, so this pair must refuse every frame
	switch_host #(.FRAME_BITS(20)) u_switch_host_2 (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start2),
		.tx_word_i(20'hFFFFF), .busy_o(), .done_o(), .rx_word_o(), .link(link2.host));
	switch_device u_switch_device_2 (.clk_i(clk_i), .rst_n_i(rst_n_i), .direct_drive_five_i(d5),
		.direct_drive_six_i(d6), .short_fault_i(sh), .thermal_limit_i(th), .open_load_i(ol), .drive_on_o(drive2),
		.detect_en_o(det2), .frame_accepted_o(), .frame_rejected_o(rej2), .link(link2.device));

	// Clock, 25 ns period
	always #12.5 clk_i = ~clk_i;

	// Verdict pulses are one cycle wide, so they are caught here
	always @(posedge clk_i) begin
		cycles++;
		if (rej2 === 1'b1) seen_rej <= 1'b1;
		if (acc === 1'b1) n_acc <= n_acc + 1;
		if (done_o === 1'b1) n_done <= n_done + 1;
		if (cycles == 10000) begin
			fails++;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One frame; waits on the host handshake, bounded, then lets the device apply the command
	task automatic send(input logic [31:0] w);
		int n;
		n = 0;
		@(negedge clk_i);
		tx_word = w;
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		while (busy_o !== 1'b0 && n < 600) begin
			@(negedge clk_i);
			n++;
		end
		repeat (4) @(negedge clk_i);
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		{clk_i, rst_n_i, start_i, start2, d5, d6, seen_rej} = 7'h00;
		{sh, th, ol, tx_word} = 56'h0;
		{fails, checked, cycles, n_acc, n_done} = '0;
		repeat (16) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		for (int i = 0; i < 7; i++) begin
			{cmd, sh, th, ol, d5, d6, exp_st, exp_dr} = rows[i];
			repeat (4) @(negedge clk_i);
			send({~cmd, cmd});
			check("status", {8'h00, exp_st, ~cmd}, rx_word);
			check("drive", 32'(exp_dr), 32'(drive_on_o));
			check("detect", 32'(cmd[15:8]), 32'(detect_en_o));
		end
		check("accepted", 32'(7), 32'(n_acc));
		check("done", 32'(7), 32'(n_done));
		// Refused frame leaves the second device at its reset state
		@(negedge clk_i);
		start2 = 1'b1;
		@(negedge clk_i);
		start2 = 1'b0;
		repeat (240) @(negedge clk_i);
		check("rejected", 32'(1), 32'(seen_rej));
		check("drive2", 32'(0), 32'({drive2, det2}));
		// Reset in mid-run clears a live command, and the link works again once released
		send(32'h00003CC3);
		check("live", 32'h000000C3, 32'(drive_on_o));
		rst_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		check("reset", 32'(0), 32'({drive_on_o, detect_en_o}));
		rst_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		send(32'hA5A50081);
		check("restart", 32'h0000A5A5, rx_word);
		check("drive4", 32'h00000081, 32'(drive_on_o));
		end_of_test();
	end
endmodule // spi_octal_switch_control_test

// *** verif/switch_link_props.sv ***
// Checker for the first serial switch link and the device behind it
module switch_link_props (
	// System
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	// Link
	input wire logic              serial_clk,
	input wire logic              select_n,
	input wire logic              status_out,
	input wire logic              status_oe,
	// Device outputs
	input wire switch_pkg::chan_t drive_on_o,
	input wire switch_pkg::chan_t detect_en_o,
	input wire logic              frame_accepted_o,
	input wire logic              frame_rejected_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import switch_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	logic [5:0] rises;
	logic [5:0] falls;

	// Edge counts per frame; falls are kept after the frame so the verdict can be judged
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rises <= 6'h00;
			falls <= 6'h00;
		end else if ($fell(select_n)) begin
			rises <= 6'h00;
			falls <= 6'h00;
		end else if (!select_n) begin
			rises <= rises + {5'h00, $rose(serial_clk)};
			falls <= falls + {5'h00, $fell(serial_clk)};
		end
	end

	wire count_ok     = (falls >= 6'h10) && (falls[2:0] == 3'h0);
	wire in_high_byte = !select_n && !serial_clk && (rises >= 6'h01) && (rises <= 6'h08);

	sequence frame_end;
		$rose(select_n);
	endsequence
	sequence verdict;
		##[1:8] (frame_accepted_o || frame_rejected_o);
	endsequence
	// Drive follows the accept pulse by one register stage, so three cycles of history suffice
	sequence recent_accept;
		frame_accepted_o || $past(frame_accepted_o) || $past(frame_accepted_o, 2) || $past(frame_accepted_o, 3);
	endsequence

	oe_idle_a: assert property (select_n |-> !status_oe) else $error("status driven while deselected");
	clk_idle_a: assert property (select_n |-> !serial_clk) else $error("serial clock runs while deselected");
	lead_low_a: assert property ($fell(select_n) |-> (!serial_clk)[*3]) else $error("lead time too short");
	oe_rise_a: assert property ($rose(status_oe) |-> serial_clk && !select_n) else $error("enable off first rise");
	high_byte_a: assert property (in_high_byte |-> !status_out) else $error("status upper byte not zero");
	cmd_hold_a: assert property (!select_n |-> $stable(detect_en_o)) else $error("detect changed mid frame");
	verdict_due_a: assert property (frame_end |-> verdict) else $error("frame never judged");
	accept_count_a: assert property (frame_accepted_o |-> count_ok) else $error("bad count accepted");
	reject_count_a: assert property (frame_rejected_o |-> !count_ok) else $error("good count rejected");
	update_cause_a: assert property ($changed(drive_on_o & 8'hCF) |-> recent_accept)
		else $error("drive changed without frame");
endmodule // switch_link_props
